// *** rtl/tcs_serial_ctrl.sv ***
// Two-wire control interface of a synthesized tuner
// Notes on behaviour
// - 15-bit divider, reset to zero
// - Start-point field resets to 011
// - Reference ratio field resets to 111
// - Pump current code, reset 11
// - Port bit: converter input or transistor on
// - Four band-switch drivers, reset off
// - Band bits one, two select band
// - AGC current select bit, reset 0
// - Standby stops mixer, crystal output stays
// - Test and shift bits reset 0010
// - Address-select level gives address bits
// - Start-point code alone picks level
// - Reference ratio codes, 1X1 gives 80
// - Normal mode; crystal output disable bit
// - Test bits three/two force test mode
// - Write orders of divider/control/band bytes
// - Read returns one status byte
// - Power-on flag cleared after transfer
// - Lock flag mirrors loop lock
// - Three converter bits give input band
// - Address byte 11000, address bits, rw
// - Top bit 0: divider byte pair
// - Bits 10: control one then band
// - Bits 11: control byte two
`timescale 1ns/1ns
`include "tcs_defines.svh"
module tcs_serial_ctrl (
  input  wire logic                   mclk,
  input  wire logic                   reset,
  input  wire logic                   scl_in,
  input  wire logic                   sda_in,
  output logic                        sda_out,
  output logic                        sda_oe,
  input  wire tcs_pkg::tcs_as_level_t address_select_pin,
  input  wire logic                   lock_flag,
  input  wire logic [2:0]             converter_code,
  output logic [14:0]                 divider_value,
  output logic [2:0]                  agc_start_point,
  output logic [2:0]                  ref_ratio_select,
  output logic [1:0]                  pump_current_select,
  output logic                        port_converter_select,
  output logic [4:1]                  band_switch_bits,
  output logic                        agc_current_select,
  output logic                        standby_bit,
  output logic                        test_bit_three,
  output logic                        test_bit_two,
  output logic                        agc_shift_bit,
  output logic                        crystal_output_disable,
  output logic                        test_mode,
  output logic                        crystal_output_enable,
  output logic                        agc_output_enable,
  output logic                        mixer_osc_enable,
  output logic [1:0]                  band_select,
  output logic [7:0]                  ref_divider_ratio,
  output logic [2:0]                  if_level_index
);
  import tcs_pkg::*;

  logic [2:0] scl_s_q, sda_s_q;
  logic       scl_q, sda_q;
  logic [1:0] as_s1_q, as_s2_q, as_s3_q;
  logic [1:0] as_q;
  logic       lock_s1_q, lock_s2_q, lock_s3_q, lock_q;
  logic [2:0] cv_s1_q, cv_s2_q, cv_s3_q, cv_q;
  tcs_state_t state_q;
  tcs_next_t  next_q;
  logic [7:0] shift_q;
  logic [3:0] bit_q;
  logic       por_q;
  logic       rd_q;
  logic       wrote_q;

  // Three-stage sampling; change counts when stages two and three agree
  always_ff @(posedge mclk) begin
    scl_s_q   <= {scl_s_q[1:0], scl_in};
    sda_s_q   <= {sda_s_q[1:0], sda_in};
    as_s1_q   <= address_select_pin;
    as_s2_q   <= as_s1_q;
    as_s3_q   <= as_s2_q;
    lock_s1_q <= lock_flag;
    lock_s2_q <= lock_s1_q;
    lock_s3_q <= lock_s2_q;
    cv_s1_q   <= converter_code;
    cv_s2_q   <= cv_s1_q;
    cv_s3_q   <= cv_s2_q;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      scl_q  <= 1'b1;
      sda_q  <= 1'b1;
      as_q   <= 2'h1;
      lock_q <= 1'b0;
      cv_q   <= 3'h0;
    end else begin
      if (scl_s_q[1] == scl_s_q[2]) scl_q <= scl_s_q[2];
      if (sda_s_q[1] == sda_s_q[2]) sda_q <= sda_s_q[2];
      if (as_s2_q == as_s3_q) as_q <= as_s3_q;
      if (lock_s2_q == lock_s3_q) lock_q <= lock_s3_q;
      if (cv_s2_q == cv_s3_q) cv_q <= cv_s3_q;
    end
  end

  logic scl_new, sda_new, scl_rise, scl_fall, start_c, stop_c;
  assign scl_new  = (scl_s_q[1] == scl_s_q[2]) ? scl_s_q[2] : scl_q;
  assign sda_new  = (sda_s_q[1] == sda_s_q[2]) ? sda_s_q[2] : sda_q;
  assign scl_rise = !scl_q && scl_new;
  assign scl_fall = scl_q && !scl_new;
  assign start_c  = scl_q && scl_new && sda_q && !sda_new;
  assign stop_c   = scl_q && scl_new && !sda_q && sda_new;

  function automatic logic [7:0] ratio_of(input logic [2:0] rs);
    case (rs)
      3'h0:    ratio_of = 8'h18;
      3'h1:    ratio_of = 8'h1C;
      3'h2:    ratio_of = 8'h32;
      3'h3:    ratio_of = 8'h40;
      3'h4:    ratio_of = 8'h80;
      default: ratio_of = 8'h50;
    endcase
  endfunction

  // Byte fits the legal write order
  function automatic logic byte_ok(input tcs_next_t n,
                                   input logic [7:0] b);
    byte_ok = n != TCS_NEXT_NONE &&
              (n != TCS_NEXT_CB1 || b[7:6] == 2'h2);
  endfunction

  // Status byte: power-on, lock, 1, 1, 0, converter
  logic [7:0] status_byte;
  assign status_byte = {por_q, lock_q, `TCS_SB_FIXED, 1'b0, cv_q};

  // Bus state machine
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_q <= TCS_IDLE;
      next_q  <= TCS_NEXT_ANY;
      shift_q <= 8'h00;
      bit_q   <= 4'h0;
      rd_q    <= 1'b0;
      wrote_q <= 1'b0;
      sda_out <= 1'b1;
      sda_oe  <= 1'b0;
    end else if (start_c) begin
      state_q <= TCS_ADDR;
      bit_q   <= 4'h0;
      wrote_q <= 1'b0;
      sda_oe  <= 1'b0;
    end else if (stop_c) begin
      state_q <= TCS_IDLE;
      sda_oe  <= 1'b0;
    end else begin
      case (state_q)
        TCS_IDLE, TCS_SKIP: begin
          sda_oe <= 1'b0;
        end
        TCS_ADDR, TCS_WDATA: begin
          if (scl_rise) begin
            shift_q <= {shift_q[6:0], sda_new};
            bit_q   <= bit_q + 4'h1;
          end
          if (scl_fall && bit_q == 4'h8) begin
            bit_q <= 4'h0;
            if (state_q == TCS_ADDR) begin
              if (shift_q[7:3] == `TCS_ADDR_FIXED &&
                  shift_q[2:1] == as_q) begin
                rd_q    <= shift_q[0];
                next_q  <= TCS_NEXT_ANY;
                state_q <= TCS_ACK;
                sda_out <= 1'b0;
                sda_oe  <= 1'b1;
              end else begin
                state_q <= TCS_SKIP;
              end
            end else if (byte_ok(next_q, shift_q)) begin
              wrote_q <= 1'b1;
              state_q <= TCS_ACK;
              sda_out <= 1'b0;
              sda_oe  <= 1'b1;
              case (next_q)
                TCS_NEXT_DIV2: next_q <= TCS_NEXT_CB1;
                TCS_NEXT_CB1:  next_q <= TCS_NEXT_BAND;
                TCS_NEXT_BAND: next_q <= TCS_NEXT_CB2;
                TCS_NEXT_CB2:  next_q <= TCS_NEXT_NONE;
                TCS_NEXT_ANY: begin
                  if (!shift_q[7]) next_q <= TCS_NEXT_DIV2;
                  else if (!shift_q[6]) next_q <= TCS_NEXT_BAND;
                  else next_q <= TCS_NEXT_NONE;
                end
                default: next_q <= TCS_NEXT_NONE;
              endcase
            end else begin
              state_q <= TCS_SKIP;
            end
          end
        end
        TCS_ACK: begin
          if (scl_fall) begin
            if (rd_q) begin
              state_q <= TCS_RDATA;
              shift_q <= {status_byte[6:0], 1'b0};
              sda_out <= status_byte[7];
              sda_oe  <= 1'b1;
              bit_q   <= 4'h1;
            end else begin
              state_q <= TCS_WDATA;
              sda_oe  <= 1'b0;
              sda_out <= 1'b1;
            end
          end
        end
        TCS_RDATA: begin
          if (scl_fall) begin
            if (bit_q == 4'h8) begin
              state_q <= TCS_RACK;
              sda_oe  <= 1'b0;
              sda_out <= 1'b1;
            end else begin
              sda_out <= shift_q[7];
              shift_q <= {shift_q[6:0], 1'b0};
              bit_q   <= bit_q + 4'h1;
            end
          end
        end
        TCS_RACK: begin
          sda_oe <= 1'b0;
        end
        default: state_q <= TCS_IDLE;
      endcase
    end
  end

  // Field writes at the byte's last bit
  logic wr_byte;
  assign wr_byte = state_q == TCS_WDATA && scl_fall && bit_q == 4'h8 &&
                   byte_ok(next_q, shift_q) && !start_c && !stop_c;

  always_ff @(posedge mclk) begin
    if (reset) begin
      divider_value          <= `TCS_DIV_RESET;
      agc_start_point        <= `TCS_ATP_RESET;
      ref_ratio_select       <= `TCS_RS_RESET;
      pump_current_select    <= `TCS_CP_RESET;
      port_converter_select  <= `TCS_PORT_RESET;
      band_switch_bits       <= `TCS_BS_RESET;
      agc_current_select     <= `TCS_ATC_RESET;
      standby_bit            <= `TCS_STANDBY_BIT_RESET;
      {test_bit_three, test_bit_two, agc_shift_bit,
       crystal_output_disable} <= `TCS_TEST_RESET;
    end else if (wr_byte) begin
      case (next_q)
        TCS_NEXT_DIV2: divider_value[7:0] <= shift_q;
        TCS_NEXT_BAND: begin
          pump_current_select   <= shift_q[7:6];
          port_converter_select <= shift_q[4];
          band_switch_bits      <= shift_q[3:0];
        end
        TCS_NEXT_CB1: begin
          agc_start_point  <= shift_q[5:3];
          ref_ratio_select <= shift_q[2:0];
        end
        TCS_NEXT_ANY: begin
          if (!shift_q[7]) begin
            divider_value[14:8] <= shift_q[6:0];
          end else if (!shift_q[6]) begin
            agc_start_point  <= shift_q[5:3];
            ref_ratio_select <= shift_q[2:0];
          end else begin
            agc_current_select     <= shift_q[5];
            standby_bit            <= shift_q[4];
            test_bit_three         <= shift_q[3];
            test_bit_two           <= shift_q[2];
            agc_shift_bit          <= shift_q[1];
            crystal_output_disable <= shift_q[0];
          end
        end
        TCS_NEXT_CB2: begin
          agc_current_select     <= shift_q[5];
          standby_bit            <= shift_q[4];
          test_bit_three         <= shift_q[3];
          test_bit_two           <= shift_q[2];
          agc_shift_bit          <= shift_q[1];
          crystal_output_disable <= shift_q[0];
        end
        default: divider_value <= divider_value;
      endcase
    end
  end

  // Power-on flag: set at reset, cleared by stop after a transfer
  always_ff @(posedge mclk) begin
    if (reset) begin
      por_q <= 1'b1;
    end else if (stop_c && (wrote_q || state_q == TCS_RACK)) begin
      por_q <= 1'b0;
    end
  end

  // Decoded analog controls
  logic tm;
  assign tm = test_bit_three | test_bit_two;
  always_ff @(posedge mclk) begin
    if (reset) begin
      test_mode             <= 1'b0;
      crystal_output_enable <= 1'b0;
      agc_output_enable     <= 1'b0;
      mixer_osc_enable      <= 1'b0;
      band_select           <= 2'h0;
      ref_divider_ratio     <= 8'h00;
      if_level_index        <= 3'h0;
    end else begin
      test_mode             <= tm;
      crystal_output_enable <= !tm && !crystal_output_disable;
      agc_output_enable     <= !tm && agc_start_point != 3'h7;
      mixer_osc_enable      <= !standby_bit;
      band_select           <= {band_switch_bits[1], band_switch_bits[2]};
      ref_divider_ratio     <= ratio_of(ref_ratio_select);
      if_level_index        <= agc_start_point;
    end
  end
endmodule // tcs_serial_ctrl

// *** rtl/tcs_defines.svh ***
// Constants for the tuner control serial interface
`ifndef TCS_DEFINES_SVH
`define TCS_DEFINES_SVH
`define TCS_ADDR_FIXED      5'h18
`define TCS_DIV_RESET       15'h0000
`define TCS_ATP_RESET       3'h3
`define TCS_RS_RESET        3'h7
`define TCS_CP_RESET        2'h3
`define TCS_PORT_RESET      1'h0
`define TCS_BS_RESET        4'h0
`define TCS_ATC_RESET       1'h0
`define TCS_STANDBY_BIT_RESET      1'h0
`define TCS_TEST_RESET      4'h2
`define TCS_SB_FIXED        2'h3
`define TCS_CONV_MAX        3'h4
`endif

// *** rtl/tcs_pkg.sv ***
// Types for the tuner control serial interface
package tcs_pkg;
  typedef enum logic [2:0] {
    TCS_IDLE  = 3'b000,
    TCS_ADDR  = 3'b001,
    TCS_WDATA = 3'b010,
    TCS_RDATA = 3'b011,
    TCS_ACK   = 3'b100,
    TCS_RACK  = 3'b101,
    TCS_SKIP  = 3'b110
  } tcs_state_t;
  typedef enum logic [2:0] {
    TCS_NEXT_ANY  = 3'b000,
    TCS_NEXT_DIV2 = 3'b001,
    TCS_NEXT_BAND = 3'b010,
    TCS_NEXT_CB2  = 3'b011,
    TCS_NEXT_NONE = 3'b100,
    TCS_NEXT_CB1  = 3'b101
  } tcs_next_t;
  typedef enum logic [1:0] {
    TCS_AS_LOW  = 2'b00,
    TCS_AS_MID2 = 2'b01,
    TCS_AS_MID1 = 2'b10,
    TCS_AS_HIGH = 2'b11
  } tcs_as_level_t;
endpackage : tcs_pkg

// *** tb/tcs_serial_ctrl_props.sv ***
// Checker for the tuner control serial interface
`timescale 1ns/1ns
module tcs_serial_ctrl_props (
  input wire logic        mclk,
  input wire logic        reset,
  input wire logic [14:0] divider_value,
  input wire logic [2:0]  agc_start_point,
  input wire logic [2:0]  ref_ratio_select,
  input wire logic [1:0]  pump_current_select,
  input wire logic        port_converter_select,
  input wire logic [4:1]  band_switch_bits,
  input wire logic        agc_current_select,
  input wire logic        standby_bit,
  input wire logic        test_bit_three,
  input wire logic        test_bit_two,
  input wire logic        agc_shift_bit,
  input wire logic        crystal_output_disable,
  input wire logic        test_mode,
  input wire logic        crystal_output_enable,
  input wire logic        agc_output_enable,
  input wire logic        mixer_osc_enable,
  input wire logic [1:0]  band_select,
  input wire logic [7:0]  ref_divider_ratio
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  property p_div_rst;
    $fell(reset) |-> divider_value == 15'h0000; endproperty
  a_div_rst: assert property (p_div_rst) else $error("div reset");
  property p_ctl_rst; $fell(reset) |-> {agc_start_point, ref_ratio_select,
    pump_current_select, port_converter_select, band_switch_bits}
    == 13'h0FE0; endproperty
  a_ctl_rst: assert property (p_ctl_rst) else $error("ctl reset");
  property p_cb2_rst; $fell(reset) |-> {agc_current_select, standby_bit,
    test_bit_three, test_bit_two, agc_shift_bit,
    crystal_output_disable} == 6'h02; endproperty
  a_cb2_rst: assert property (p_cb2_rst) else $error("cb2 reset");
  property p_test; test_bit_three || test_bit_two |=> test_mode &&
    !crystal_output_enable && !agc_output_enable; endproperty
  a_test: assert property (p_test) else $error("test mode");
  property p_xtal; !test_bit_three && !test_bit_two |=> !test_mode &&
    crystal_output_enable == !$past(crystal_output_disable); endproperty
  a_xtal: assert property (p_xtal) else $error("crystal out");
  property p_standby_bit;
    standby_bit |=> !mixer_osc_enable; endproperty
  a_standby_bit: assert property (p_standby_bit) else $error("standby");
  property p_ratio; ref_ratio_select[2] && ref_ratio_select[0]
    |=> ref_divider_ratio == 8'h50; endproperty
  a_ratio: assert property (p_ratio) else $error("ratio");
  property p_band; 1'b1 |=> band_select ==
    $past({band_switch_bits[1], band_switch_bits[2]}); endproperty
  a_band: assert property (p_band) else $error("band");
endmodule // tcs_serial_ctrl_props

// *** tb/tcs_host_model.sv ***
// Bus host model of the two-wire control bus
`timescale 1ns/1ns
module tcs_host_model (
  input  wire logic mclk,
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Quarter of an 800 ns bit
  task automatic wq();
    repeat (2) @(posedge mclk);
    #1;
  endtask
  task automatic start();
    sda_low = 1'b0;
    wq();
    scl = 1'b1;
    wq();
    sda_low = 1'b1;
    wq();
    scl = 1'b0;
    wq();
  endtask
  task automatic stop();
    sda_low = 1'b1;
    wq();
    scl = 1'b1;
    wq();
    sda_low = 1'b0;
    wq();
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda_low = !b;
    wq();
    scl = 1'b1;
    wq();
    r = sda_line;
    wq();
    scl = 1'b0;
    wq();
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic rbyte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(!ack, r);
  endtask
endmodule // tcs_host_model

// *** tb/tcs_serial_ctrl_test.sv ***
// Testbench for the tuner control serial interface
`timescale 1ns/1ns
module tcs_serial_ctrl_test;
  import tcs_pkg::*;
  logic          mclk, reset, sda_out, sda_oe, lock_flag;
  logic          f_port, f_acur, f_stdby, f_tb3, f_tb2, f_shift, f_xdis;
  logic          tmode, xen, men, aen, scl, sda_low;
  logic [1:0]    f_pump, bsel;
  logic [2:0]    conv, f_start, f_ratio, lvl;
  logic [4:1]    f_band;
  logic [7:0]    rdr;
  logic [14:0]   f_div;
  wire           sda_line = !(sda_low || (sda_oe && !sda_out));
  tcs_as_level_t as_pin;
  int            errors, checks;
  tcs_host_model host (.mclk(mclk), .sda_line(sda_line), .scl(scl),
    .sda_low(sda_low));
  tcs_serial_ctrl DUT (.mclk(mclk), .reset(reset), .scl_in(scl),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .address_select_pin(as_pin), .lock_flag(lock_flag),
    .converter_code(conv), .divider_value(f_div),
    .agc_start_point(f_start), .ref_ratio_select(f_ratio),
    .pump_current_select(f_pump), .port_converter_select(f_port),
    .band_switch_bits(f_band), .agc_current_select(f_acur),
    .standby_bit(f_stdby), .test_bit_three(f_tb3), .test_bit_two(f_tb2),
    .agc_shift_bit(f_shift), .crystal_output_disable(f_xdis),
    .test_mode(tmode), .crystal_output_enable(xen),
    .agc_output_enable(aen), .mixer_osc_enable(men), .band_select(bsel),
    .ref_divider_ratio(rdr), .if_level_index(lvl));
  task automatic stop_test();
    if (errors == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] d, input logic a);
    logic k;
    host.wbyte(d, k);
    chk(16'(k), 16'(a));
  endtask
  task automatic adr(input logic rw);
    host.start();
    wr({5'h18, as_pin, rw}, 1'b1);
  endtask
  task automatic rd(input logic [7:0] e);
    logic [7:0] d;
    adr(1'b1);
    host.rbyte(1'b1, d);
    host.stop();
    chk(16'(d), 16'(e));
  endtask
  task automatic t_reset();
    chk(16'(f_div), 16'h0000);
    chk(16'({f_start, f_ratio, f_pump, f_port, f_band}), 16'h0FE0);
    chk(16'({f_acur,f_stdby,f_tb3,f_tb2,f_shift,f_xdis}), 16'h02);
    chk(16'({tmode, xen, men, rdr}), 16'h0350);
    chk(16'({aen, bsel, lvl}), 16'h0023);
    rd(8'hF1);
  endtask
  task automatic t_addr();
    logic [14:0] e;
    e = 15'h0000;
    for (int l = 0; l < 4; l++) begin
      for (int m = 0; m < 4; m++) begin
        as_pin = tcs_as_level_t'(l);
        host.start();
        wr({5'h18, 2'(m), 1'b0}, l == m);
        if (l == m) begin
          wr(8'(l * 5), 1'b1);
          wr(8'(l * 51 + 1), 1'b1);
          e = {7'(l * 5), 8'(l * 51 + 1)};
        end
        host.stop();
        chk(16'(f_div), 16'(e));
      end
    end
  endtask
  task automatic t_full();
    adr(1'b0);
    wr(8'h2A, 1'b1);
    wr(8'h5C, 1'b1);
    wr(8'h9D, 1'b1);
    wr(8'h5A, 1'b1);
    wr(8'hD1, 1'b1);
    wr(8'h00, 1'b0);
    host.stop();
    chk(16'(f_div), 16'h2A5C);
    chk(16'({f_start, f_ratio, f_pump, f_port, f_band}), 16'h0EBA);
    chk(16'({f_acur,f_stdby,f_tb3,f_tb2,f_shift,f_xdis}), 16'h11);
    chk(16'({tmode, xen, men, rdr}), 16'h0050);
    chk(16'({aen, bsel, lvl}), 16'h002B);
  endtask
  task automatic t_order();
    logic [7:0] cb [4] = '{8'hC4, 8'hC8, 8'hE1, 8'hC0};
    logic [2:0] ex [4] = '{3'h4, 3'h4, 3'h1, 3'h3};
    adr(1'b0);
    wr(8'hA0, 1'b1);
    wr(8'h01, 1'b1);
    host.stop();
    chk(16'(rdr), 16'h0018);
    lock_flag = 1'b0;
    conv = 3'h4;
    rd(8'h34);
    for (int i = 0; i < 4; i++) begin
      adr(1'b0);
      wr(cb[i], 1'b1);
      host.stop();
      chk(16'({tmode, xen, aen}), 16'(ex[i]));
    end
    chk(16'({aen, bsel, lvl}), 16'h0034);
  endtask
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  initial begin
    reset = 1'b1;
    as_pin = TCS_AS_MID2;
    lock_flag = 1'b1;
    conv = 3'h1;
    repeat (20) @(posedge mclk);
    #1 reset = 1'b0;
    repeat (8) @(posedge mclk);
    #1;
    t_reset();
    t_addr();
    t_full();
    t_order();
    stop_test();
  end
  initial begin
    repeat (100000) @(posedge mclk);
    errors++;
    stop_test();
  end
endmodule // tcs_serial_ctrl_test
bind tcs_serial_ctrl tcs_serial_ctrl_props u_props (
  .mclk                   (mclk),
  .reset                  (reset),
  .divider_value          (divider_value),
  .agc_start_point        (agc_start_point),
  .ref_ratio_select       (ref_ratio_select),
  .pump_current_select    (pump_current_select),
  .port_converter_select  (port_converter_select),
  .band_switch_bits       (band_switch_bits),
  .agc_current_select     (agc_current_select),
  .standby_bit            (standby_bit),
  .test_bit_three         (test_bit_three),
  .test_bit_two           (test_bit_two),
  .agc_shift_bit          (agc_shift_bit),
  .crystal_output_disable (crystal_output_disable),
  .test_mode              (test_mode),
  .crystal_output_enable  (crystal_output_enable),
  .agc_output_enable      (agc_output_enable),
  .mixer_osc_enable       (mixer_osc_enable),
  .band_select            (band_select),
  .ref_divider_ratio      (ref_divider_ratio)
);
